// >>> ctcc_pkg.sv
// Constants, field layouts and state types of the compare timer/counter control block.
// Assumes an AHB-Lite master, one system clock and an asynchronous active-low reset.
//
// Overview of operation
// - run_control 0 stops and clears the counter; 1 commands counting to start.
// - start_source_select picks software or external trigger start; no trigger in event mode.
// - trigger_both_edges honours one or both edges; only with trigger start, not event mode.
// - trigger_edge_polarity 0 means rising edge; also picks the counted edge for events.
// - pulse_mode_select 0 gives timer or event counter; 1 gives pulse output mode.
// - pulse_initial_polarity sets forward or reverse output level right after start.
// - block_soft_reset resets all but the prescale halve bit and zeroes pulse_output; live irq pulse survives.
// - output_flop_control write clears or sets the timer output flip-flop directly.
// - count_clock_select divides fc, halved option; 110 unused, 111 pin; pulse limits.
// - compare_register_count selects A, A+B or A+B+C; code 11 reserved.
// - trigger_input_disable 1 forces the trigger input to a constant low level.
// - Writes to compare B and C ignored unless pulse mode enables them.
// - With trigger start, writing 00 to start source and run halts counting.
// - Timer counts up; on equal to compare A it raises irq, clears, continues unless one_shot is set outside event mode.
package ctcc_pkg;

    // ------------------------------------------------------------
    // Widths and register map
    // ------------------------------------------------------------
    localparam int unsigned CNT_W   = 16;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned PRE_W   = 13;

    localparam logic [7:0] OFS_CTRL1    = 8'h00;
    localparam logic [7:0] OFS_CTRL2    = 8'h04;
    localparam logic [7:0] OFS_CMPA     = 8'h08;
    localparam logic [7:0] OFS_CMPB     = 8'h0c;
    localparam logic [7:0] OFS_CMPC     = 8'h10;
    localparam logic [7:0] OFS_COUNT    = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;
    localparam logic [7:0] OFS_PRESCALE = 8'h1c;

    localparam logic [7:0]       CTRL1_RESET = 8'h00;
    localparam logic [7:0]       CTRL2_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CMP_RESET   = 16'h0000;

    // ------------------------------------------------------------
    // Clock source and compare register codes
    // ------------------------------------------------------------
    localparam logic [2:0] CLK_SEL_DIV_MAX  = 3'h5;
    localparam logic [2:0] CLK_SEL_PULSE_LO = 3'h4;
    localparam logic [2:0] CLK_SEL_PULSE_HI = 3'h5;
    localparam logic [2:0] CLK_SEL_UNUSED   = 3'h6;
    localparam logic [2:0] CLK_SEL_PIN      = 3'h7;

    localparam logic [3:0] DIV_SHIFT_0 = 4'hb;
    localparam logic [3:0] DIV_SHIFT_1 = 4'h7;
    localparam logic [3:0] DIV_SHIFT_2 = 4'h5;
    localparam logic [3:0] DIV_SHIFT_3 = 4'h3;
    localparam logic [3:0] DIV_SHIFT_4 = 4'h2;
    localparam logic [3:0] DIV_SHIFT_5 = 4'h1;

    localparam logic [1:0] REGCNT_A   = 2'h0;
    localparam logic [1:0] REGCNT_AB  = 2'h1;
    localparam logic [1:0] REGCNT_ABC = 2'h2;

    // ------------------------------------------------------------
    // Register layouts and types
    // ------------------------------------------------------------
    typedef struct packed {
        logic block_soft_reset;
        logic pulse_initial_polarity;
        logic pulse_mode_select;
        logic one_shot;
        logic trigger_edge_polarity;
        logic trigger_both_edges;
        logic start_source_select;
        logic run_control;
    } ctcc_ctrl1_s;

    typedef struct packed {
        logic       reserved;
        logic       trigger_input_disable;
        logic [1:0] compare_register_count;
        logic [2:0] count_clock_select;
        logic       output_flop_control;
    } ctcc_ctrl2_s;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_WAIT_TRIG,
        RUN_COUNT
    } ctcc_run_e;

    typedef enum logic [3:0] {
        REG_CTRL1,
        REG_CTRL2,
        REG_CMPA,
        REG_CMPB,
        REG_CMPC,
        REG_COUNT,
        REG_STATUS,
        REG_PRESCALE,
        REG_NONE
    } ctcc_reg_e;

endpackage

// >>> ctcc_tick_gen.sv
// Prescaler that turns the system clock into count ticks for the timer.
// Assumes clear is held while the timer is idle so each run starts aligned.
`timescale 1ns/1ns
module ctcc_tick_gen (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Configuration
    input  wire logic       clear,
    input  wire logic [2:0] clk_sel,
    input  wire logic       halve,
    input  wire logic       pulse_mode,
    // Tick out
    output logic            tick
);

    // ------------------------------------------------------------
    // Divider lookup
    // ------------------------------------------------------------
    function automatic logic [3:0] div_shift(input logic [2:0] sel);
        case (sel)
            3'h0:    div_shift = ctcc_pkg::DIV_SHIFT_0;
            3'h1:    div_shift = ctcc_pkg::DIV_SHIFT_1;
            3'h2:    div_shift = ctcc_pkg::DIV_SHIFT_2;
            3'h3:    div_shift = ctcc_pkg::DIV_SHIFT_3;
            3'h4:    div_shift = ctcc_pkg::DIV_SHIFT_4;
            default: div_shift = ctcc_pkg::DIV_SHIFT_5;
        endcase
    endfunction

    typedef struct packed {
        logic [ctcc_pkg::PRE_W-1:0] div;
        logic                       tick;
    } ctcc_tick_state_s;

    ctcc_tick_state_s s_q;
    ctcc_tick_state_s s_d;
    logic [3:0]                 shift;
    logic [ctcc_pkg::PRE_W-1:0] mask;
    logic                       allowed;

    always_comb begin
        s_d   = s_q;
        shift = div_shift(clk_sel) + {3'h0, halve};
        mask  = ctcc_pkg::PRE_W'((1 << shift) - 1);
        allowed = (clk_sel <= ctcc_pkg::CLK_SEL_DIV_MAX);
        if (pulse_mode) begin
            allowed = ((clk_sel == ctcc_pkg::CLK_SEL_PULSE_LO) && !halve) ||
                      (clk_sel == ctcc_pkg::CLK_SEL_PULSE_HI);
        end
        s_d.tick = 1'b0;
        if (clear) begin
            s_d.div = '0;
        end else begin
            s_d.div  = s_q.div + 1'b1;
            s_d.tick = allowed && ((s_q.div & mask) == mask);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

// >>> ctcc_timer.sv
// Compare timer/counter control block with an AHB-Lite register slave.
// Assumes one AHB-Lite master whose hready is this slave's hreadyout,
// and an asynchronous trigger pin that is synchronised here.
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module ctcc_timer (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [ctcc_pkg::DATA_W-1:0]   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [ctcc_pkg::DATA_W-1:0]        hrdata,
    // Pins
    input  wire logic                          trigger_pin,
    output logic                               pulse_output,
    output logic                               compare_match_irq
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic ctcc_pkg::ctcc_reg_e decode(input logic [ctcc_pkg::ADDR_W-1:0] a);
        case (a)
            ctcc_pkg::OFS_CTRL1:    decode = ctcc_pkg::REG_CTRL1;
            ctcc_pkg::OFS_CTRL2:    decode = ctcc_pkg::REG_CTRL2;
            ctcc_pkg::OFS_CMPA:     decode = ctcc_pkg::REG_CMPA;
            ctcc_pkg::OFS_CMPB:     decode = ctcc_pkg::REG_CMPB;
            ctcc_pkg::OFS_CMPC:     decode = ctcc_pkg::REG_CMPC;
            ctcc_pkg::OFS_COUNT:    decode = ctcc_pkg::REG_COUNT;
            ctcc_pkg::OFS_STATUS:   decode = ctcc_pkg::REG_STATUS;
            ctcc_pkg::OFS_PRESCALE: decode = ctcc_pkg::REG_PRESCALE;
            default:                decode = ctcc_pkg::REG_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ctcc_pkg::ctcc_ctrl1_s          ctrl1;
        ctcc_pkg::ctcc_ctrl2_s          ctrl2;
        logic                           halve;
        logic [ctcc_pkg::CNT_W-1:0]     cmp_a;
        logic [ctcc_pkg::CNT_W-1:0]     cmp_b;
        logic [ctcc_pkg::CNT_W-1:0]     cmp_c;
        logic [ctcc_pkg::CNT_W-1:0]     count;
        ctcc_pkg::ctcc_run_e            run;
        logic                           flop;
        logic                           pulse;
        logic                           irq;
        logic                           pin_meta;
        logic                           pin_sync;
        logic                           pin_prev;
        logic                           dp_valid;
        logic                           dp_write;
        logic [ctcc_pkg::ADDR_W-1:0]    dp_addr;
        logic                           rd_done;
        logic [ctcc_pkg::DATA_W-1:0]    rdata;
    } ctcc_state_s;

    ctcc_state_s s_q;
    ctcc_state_s s_d;

    logic                         pre_tick;
    logic                         pin_lvl;
    logic                         pin_rise;
    logic                         pin_fall;
    logic                         trig_edge;
    logic                         event_edge;
    logic                         event_mode;
    logic                         trig_start;
    logic                         count_tick;
    logic                         use_b;
    logic                         use_c;
    logic                         rd_stall;
    logic                         soft_reset;
    logic                         match_a;
    logic [ctcc_pkg::CNT_W-1:0]   count_inc;
    ctcc_pkg::ctcc_reg_e          wr_reg;
    ctcc_pkg::ctcc_reg_e          rd_reg;
    logic [ctcc_pkg::DATA_W-1:0]  rd_mux;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    ctcc_tick_gen u_tick_gen (
        .clk        (clk),
        .reset_n    (reset_n),
        .clear      (s_q.run == ctcc_pkg::RUN_IDLE),
        .clk_sel    (s_q.ctrl2.count_clock_select),
        .halve      (s_q.halve),
        .pulse_mode (s_q.ctrl1.pulse_mode_select),
        .tick       (pre_tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;

        // Two-flop synchroniser; only the second stage is looked at
        s_d.pin_meta = trigger_pin;
        s_d.pin_sync = s_q.pin_meta;
        pin_lvl    = s_q.pin_sync && !s_q.ctrl2.trigger_input_disable;
        s_d.pin_prev = pin_lvl;
        pin_rise   = pin_lvl && !s_q.pin_prev;
        pin_fall   = !pin_lvl && s_q.pin_prev;

        event_mode = !s_q.ctrl1.pulse_mode_select &&
                     (s_q.ctrl2.count_clock_select == ctcc_pkg::CLK_SEL_PIN);
        event_edge = s_q.ctrl1.trigger_edge_polarity ? pin_fall : pin_rise;
        trig_edge  = s_q.ctrl1.trigger_both_edges ? (pin_rise || pin_fall) : event_edge;
        // Trigger start not in event mode
        trig_start = s_q.ctrl1.start_source_select && !event_mode;
        count_tick = event_mode ? event_edge : pre_tick;

        use_b = s_q.ctrl1.pulse_mode_select &&
                ((s_q.ctrl2.compare_register_count == ctcc_pkg::REGCNT_AB) ||
                 (s_q.ctrl2.compare_register_count == ctcc_pkg::REGCNT_ABC));
        use_c = s_q.ctrl1.pulse_mode_select &&
                (s_q.ctrl2.compare_register_count == ctcc_pkg::REGCNT_ABC);

        match_a   = (s_q.count == s_q.cmp_a);
        count_inc = s_q.count + 1'b1;

        // Counter sequencing
        case (s_q.run)
            ctcc_pkg::RUN_IDLE: begin
                s_d.count = '0;
                if (s_q.ctrl1.run_control) begin
                    if (trig_start) begin
                        s_d.run = ctcc_pkg::RUN_WAIT_TRIG;
                    end else begin
                        s_d.run = ctcc_pkg::RUN_COUNT;
                        s_d.flop = s_q.ctrl1.pulse_initial_polarity;
                    end
                end
            end
            ctcc_pkg::RUN_WAIT_TRIG: begin
                if (trig_edge) begin
                    s_d.run = ctcc_pkg::RUN_COUNT;
                    s_d.flop = s_q.ctrl1.pulse_initial_polarity;
                end
            end
            ctcc_pkg::RUN_COUNT: begin
                if (count_tick) begin
                    if (match_a) begin
                        s_d.count = '0;
                        s_d.irq   = 1'b1;
                        if (s_q.ctrl1.pulse_mode_select) begin
                            s_d.flop = !s_q.flop;
                        end
                        // One-shot ends the run at the cycle end
                        if (s_q.ctrl1.one_shot && !event_mode) begin
                            s_d.ctrl1.run_control         = 1'b0;
                            s_d.ctrl1.start_source_select = 1'b0;
                            s_d.run                       = ctcc_pkg::RUN_IDLE;
                        end
                    end else begin
                        s_d.count = count_inc;
                        if ((use_b && (s_q.count == s_q.cmp_b)) ||
                            (use_c && (s_q.count == s_q.cmp_c))) begin
                            s_d.irq  = 1'b1;
                            s_d.flop = !s_q.flop;
                        end
                    end
                end
            end
            default: begin
                s_d.run = ctcc_pkg::RUN_IDLE;
            end
        endcase

        if (!s_q.ctrl1.run_control) begin
            s_d.run   = ctcc_pkg::RUN_IDLE;
            s_d.count = '0;
        end

        s_d.pulse = s_q.ctrl1.pulse_mode_select && s_q.flop;

        // --------------------------------------------------------
        // AHB-Lite address and data phases
        // --------------------------------------------------------
        // Reads take one wait state so hrdata can come from a register
        rd_stall = s_q.dp_valid && !s_q.dp_write && !s_q.rd_done;
        rd_reg   = decode(s_q.dp_addr);
        wr_reg   = ctcc_pkg::REG_NONE;
        if (s_q.dp_valid && s_q.dp_write) begin
            wr_reg = decode(s_q.dp_addr);
        end

        case (rd_reg)
            ctcc_pkg::REG_CTRL1: begin
                rd_mux = {24'h0, 1'b0, s_q.ctrl1[6:0]};
            end
            ctcc_pkg::REG_CTRL2: begin
                rd_mux = {24'h0, 1'b0, s_q.ctrl2[6:0]};
            end
            ctcc_pkg::REG_CMPA:     rd_mux = {16'h0, s_q.cmp_a};
            ctcc_pkg::REG_CMPB:     rd_mux = {16'h0, s_q.cmp_b};
            ctcc_pkg::REG_CMPC:     rd_mux = {16'h0, s_q.cmp_c};
            ctcc_pkg::REG_COUNT:    rd_mux = {16'h0, s_q.count};
            ctcc_pkg::REG_STATUS: begin
                rd_mux = {28'h0, s_q.pulse, s_q.flop,
                          (s_q.run == ctcc_pkg::RUN_WAIT_TRIG),
                          (s_q.run == ctcc_pkg::RUN_COUNT)};
            end
            ctcc_pkg::REG_PRESCALE: rd_mux = {31'h0, s_q.halve};
            default:                rd_mux = '0;
        endcase

        if (rd_stall) begin
            s_d.rdata   = rd_mux;
            s_d.rd_done = 1'b1;
        end else begin
            s_d.rd_done = 1'b0;
        end

        if (hready) begin
            s_d.dp_valid = hsel && htrans[1];
            s_d.dp_write = hwrite;
            s_d.dp_addr  = haddr[ctcc_pkg::ADDR_W-1:0];
        end

        // Register writes; software writes override the sequencer
        soft_reset = 1'b0;
        case (wr_reg)
            ctcc_pkg::REG_CTRL1: begin
                s_d.ctrl1  = ctcc_pkg::ctcc_ctrl1_s'(hwdata[7:0]);
                soft_reset = hwdata[7];
            end
            ctcc_pkg::REG_CTRL2: begin
                s_d.ctrl2          = ctcc_pkg::ctcc_ctrl2_s'(hwdata[7:0]);
                s_d.ctrl2.reserved = 1'b0;
                s_d.flop = hwdata[0];
            end
            ctcc_pkg::REG_CMPA: begin
                s_d.cmp_a = hwdata[ctcc_pkg::CNT_W-1:0];
            end
            ctcc_pkg::REG_CMPB: begin
                if (use_b) begin
                    s_d.cmp_b = hwdata[ctcc_pkg::CNT_W-1:0];
                end
            end
            ctcc_pkg::REG_CMPC: begin
                if (use_c) begin
                    s_d.cmp_c = hwdata[ctcc_pkg::CNT_W-1:0];
                end
            end
            ctcc_pkg::REG_PRESCALE: begin
                s_d.halve = hwdata[0];
            end
            default: begin
                s_d.halve = s_d.halve;
            end
        endcase

        if (soft_reset) begin
            s_d.ctrl1 = ctcc_pkg::CTRL1_RESET;
            s_d.ctrl2 = ctcc_pkg::CTRL2_RESET;
            s_d.cmp_a = ctcc_pkg::CMP_RESET;
            s_d.cmp_b = ctcc_pkg::CMP_RESET;
            s_d.cmp_c = ctcc_pkg::CMP_RESET;
            s_d.count = '0;
            s_d.run   = ctcc_pkg::RUN_IDLE;
            s_d.flop  = 1'b0;
            s_d.pulse = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.ctrl1 <= ctcc_pkg::CTRL1_RESET;
            s_q.ctrl2 <= ctcc_pkg::CTRL2_RESET;
            s_q.cmp_a <= ctcc_pkg::CMP_RESET;
            s_q.cmp_b <= ctcc_pkg::CMP_RESET;
            s_q.cmp_c <= ctcc_pkg::CMP_RESET;
            s_q.run   <= ctcc_pkg::RUN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout         = !rd_stall;
    assign hresp             = 1'b0;
    assign hrdata            = s_q.rdata;
    assign pulse_output      = s_q.pulse;
    assign compare_match_irq = s_q.irq;

endmodule

// >>> ctcc_timer_monitor.sv
// Bus and pin assertions for the compare timer/counter control block.
// Assumes hready is tied to hreadyout and only ctcc_timer ports are seen.
`timescale 1ns/1ns
module ctcc_timer_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic        pulse_output,
    input wire logic        compare_match_irq
);
    logic rd_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rd_q <= 1'b0;
        else rd_q <= hsel && hready && htrans[1] && !hwrite;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_take; hsel && hready && htrans[1]; endsequence
    sequence s_ctrl1(b); s_take ##0 hwrite && haddr[7:0] == 8'h00 ##1 hwdata[b]; endsequence
    sequence s_stop; s_take ##0 hwrite && haddr[7:0] == 8'h00 ##1 !hwdata[0]; endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_read_wait: assert property (s_take ##0 !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (s_take ##0 hwrite |=> hreadyout) else $error("write stalled");
    a_idle_ready: assert property (!hreadyout |-> rd_q) else $error("stray wait state");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_q)) else $error("hrdata moved");
    a_unmapped_zero: assert property (s_take ##0 !hwrite && haddr[7:0] >= 8'h20 |=> ##1
        hrdata == 32'h0) else $error("unmapped read not zero");
    a_soft_pulse: assert property (s_ctrl1(7) |=> ##1 !pulse_output) else $error("pulse kept");
    a_irq_short: assert property ($rose(compare_match_irq) |=> !compare_match_irq[*2])
        else $error("irq too long");
    a_stop_quiet: assert property (s_stop |=> ##1 !compare_match_irq[*4])
        else $error("irq after stop");
endmodule
bind ctcc_timer ctcc_timer_monitor u_mon (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pulse_output(pulse_output),
    .compare_match_irq(compare_match_irq));

// >>> ctcc_trig_model.sv
// External trigger source standing at the block's pin.
// Assumes the bench raises en only while the pin is meant to be in use.
`timescale 1ns/1ns
module ctcc_trig_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Control
    input  wire logic en,
    // Pin
    output logic      trigger_pin
);
    logic [3:0] cnt_q;
    // one rising edge per 16 clocks, low when idle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q       <= 4'h0;
            trigger_pin <= 1'b0;
        end else begin
            cnt_q       <= en ? cnt_q + 4'h1 : 4'h0;
            trigger_pin <= en && cnt_q[3:2] == 2'h3;
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench for ctcc_timer over AHB-Lite plus a trigger pin model.
// Assumes a 100 MHz clock and hready fed back from hreadyout.
`timescale 1ns/1ns
module tb;
    logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, pin, pout, irq, en;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_mismatch, n_tests, cyc, n;

    ctcc_timer u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger_pin(pin),
        .pulse_output(pout), .compare_match_irq(irq));
    ctcc_trig_model u_trig (.clk(clk), .reset_n(reset_n), .en(en), .trigger_pin(pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready is judged just before the edge so the update at the edge cannot race it
    task automatic wait_rdy;
        do @(negedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic wait_irq(input int lim);
        n = 0;
        do begin @(negedge clk); n++; end while (irq !== 1'b1 && n < lim);
        @(posedge clk);
    endtask
    task automatic gap;
        repeat (3) @(negedge clk);
        @(posedge clk);
    endtask
    // Pin output is judged at a falling edge, clear of the update at the rising edge
    task automatic gap_chk(input logic e);
        repeat (3) @(negedge clk);
        chk({31'h0, pout}, {31'h0, e});
        @(posedge clk);
    endtask

    task automatic t_regs;
        rc(ctcc_pkg::OFS_CTRL1, 32'h0);
        rc(ctcc_pkg::OFS_CTRL2, 32'h0);
        rc(8'h40, 32'h0);
    endtask
    task automatic t_timer;
        bus(1'b1, ctcc_pkg::OFS_CMPA, 32'h2);
        bus(1'b1, ctcc_pkg::OFS_CTRL2, 32'h4a);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h1);
        wait_irq(100);
        wait_irq(100);
        chk(n, 32'd6);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h0);
        rc(ctcc_pkg::OFS_COUNT, 32'h0);
    endtask
    task automatic t_cmp;
        bus(1'b1, ctcc_pkg::OFS_CMPB, 32'h5);
        rc(ctcc_pkg::OFS_CMPB, 32'h0);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h20);
        bus(1'b1, ctcc_pkg::OFS_CTRL2, 32'h5a);
        bus(1'b1, ctcc_pkg::OFS_CMPB, 32'h5);
        bus(1'b1, ctcc_pkg::OFS_CMPC, 32'h9);
        rc(ctcc_pkg::OFS_CMPB, 32'h5);
        rc(ctcc_pkg::OFS_CMPC, 32'h0);
    endtask
    task automatic t_pulse;
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h61);
        gap_chk(1'b1);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h80);
        gap_chk(1'b0);
        rc(ctcc_pkg::OFS_CTRL2, 32'h0);
        rc(ctcc_pkg::OFS_CMPA, 32'h0);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h20);
        bus(1'b1, ctcc_pkg::OFS_CTRL2, 32'h5b);
        gap_chk(1'b1);
        bus(1'b1, ctcc_pkg::OFS_CTRL2, 32'h5a);
        gap_chk(1'b0);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h0);
    endtask
    task automatic t_event;
        bus(1'b1, ctcc_pkg::OFS_CMPA, 32'h2);
        bus(1'b1, ctcc_pkg::OFS_CTRL2, 32'h0e);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h3);
        en <= 1'b1;
        wait_irq(200);
        wait_irq(200);
        chk(n, 32'd48);
        bus(1'b1, ctcc_pkg::OFS_CTRL2, 32'h4e);
        gap;
        wait_irq(100);
        chk(n, 32'd100);
        en <= 1'b0;
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h0);
    endtask
    // Timer started by the pin, one-shot: waits, runs one cycle, then idles itself
    task automatic t_trig;
        bus(1'b1, ctcc_pkg::OFS_CTRL2, 32'h0a);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h13);
        rc(ctcc_pkg::OFS_STATUS, 32'h2);
        en <= 1'b1;
        wait_irq(100);
        en <= 1'b0;
        gap;
        rc(ctcc_pkg::OFS_CTRL1, 32'h10);
        rc(ctcc_pkg::OFS_COUNT, 32'h0);
        bus(1'b1, ctcc_pkg::OFS_CTRL1, 32'h0);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim;
        end
    end
    initial begin
        {reset_n, hsel, hwrite, en, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        hsel    <= 1'b1;
        t_regs;
        t_timer;
        t_cmp;
        t_pulse;
        t_event;
        t_trig;
        end_sim;
    end
endmodule
